// file: rtl/dtp_pkg.sv
// Purpose: Shared constants and types for the dual 8-bit timer pair
// Assumes: 8-bit register bus, one 200 MHz clock
// Notes: Offsets and bit positions are used by the timer pair and its bench
package dtp_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [3:0] OFS_RUN = 4'h0;
  localparam logic [3:0] OFS_LCMP = 4'h2;
  localparam logic [3:0] OFS_UCMP = 4'h3;
  localparam logic [3:0] OFS_MODE = 4'h4;
  localparam logic [3:0] OFS_FFCR = 4'h5;
  localparam logic [3:0] OFS_LCNT = 4'h6;
  localparam logic [3:0] OFS_UCNT = 4'h7;
  localparam logic [3:0] OFS_STAT = 4'h8;

  // pair_run_reg fields
  localparam int unsigned RUN_LOWER = 0;
  localparam int unsigned RUN_UPPER = 1;
  localparam int unsigned RUN_PRESC = 2;
  localparam int unsigned RUN_IDLE = 3;
  localparam int unsigned RUN_BUFEN = 7;
  localparam logic [7:0] RUN_RD_MASK = 8'h8F;

  // pair_mode_reg fields
  localparam int unsigned MODE_OP_LO = 6;
  localparam int unsigned MODE_PWM_LO = 4;
  localparam int unsigned MODE_UCLK_LO = 2;
  localparam int unsigned MODE_LCLK_LO = 0;

  // flop_control_reg fields
  localparam int unsigned FFCR_CTL_LO = 2;
  localparam int unsigned FFCR_IE = 1;
  localparam int unsigned FFCR_IS = 0;

  // Status register fields
  localparam int unsigned STAT_FLOP = 0;
  localparam int unsigned STAT_SUSP = 1;

  // Reset values
  localparam logic [7:0] RUN_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [1:0] FFCR_CTL_RD = 2'h3;

  // PWM tops and prescaler tap masks
  localparam logic [7:0] PWM_TOP6 = 8'h3F;
  localparam logic [7:0] PWM_TOP7 = 8'h7F;
  localparam logic [7:0] PWM_TOP8 = 8'hFF;
  localparam logic [7:0] TAP4_MASK = 8'h03;
  localparam logic [7:0] TAP16_MASK = 8'h0F;
  localparam logic [7:0] TAP256_MASK = 8'hFF;

  typedef enum logic [1:0] {
    OP_TIMER8 = 2'b00,
    OP_TIMER16 = 2'b01,
    OP_PPG = 2'b10,
    OP_PWM = 2'b11
  } dtp_mode_e;

  typedef enum logic [1:0] {
    FF_TOGGLE = 2'b00,
    FF_SET = 2'b01,
    FF_CLEAR = 2'b10,
    FF_HOLD = 2'b11
  } dtp_ffctl_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } dtp_req_s;
endpackage

// file: rtl/dtp_timer_pair.sv
// Purpose: Pair of cascadable 8-bit up-counting timers with shared output flop
// Assumes: Single clock; external count input is asynchronous to it
// Notes: Compare registers are write-only and read back as zero
// Function
// RULE1 - Timer8 mode: two independent interval timers, each with counter, compare, irq.
// RULE2 - Software stops a timer before changing mode, clock or compare.
// RULE3 - Run bit zero halts and clears counter; one lets it count.
// RULE4 - Lower clock: external, tap 1/4/16; upper: lower match, tap 1/16/256.
// RULE5 - Inversion enabled in timer8 mode: flop toggles on selected match.
// RULE6 - Upper clock from lower match: upper increments per lower match.
// RULE7 - Mode field 01 cascades both timers into one 16-bit timer.
// RULE8 - 16-bit mode: upper counts lower overflow regardless of its clock select.
// RULE9 - 16-bit: low byte write suspends compare, high byte write re-enables.
// RULE10 - 16-bit: lower match neither clears lower counter nor raises lower irq.
// RULE11 - 16-bit double match clears both counters, upper irq, toggles flop.
// RULE12 - Pulse mode: lower timer drives output pin; upper timer unavailable.
// RULE13 - Pulse mode: flop toggles on lower counter equal to either compare.
// RULE14 - Pulse mode: software keeps lower compare below upper compare.
// RULE15 - Pulse mode: software still sets the upper run bit.
// RULE16 - Pulse mode with buffer: buffer loads lower compare on upper match.
// RULE17 - Flop preset high gives negative pulse, preset low positive.
// RULE18 - PWM only on lower timer; upper stays an independent 8-bit timer.
// RULE19 - PWM: toggle on lower compare and on 2^n-1 overflow, n 6/7/8.
// RULE20 - PWM: lower counter cleared at each 2^n-1 overflow.
// RULE21 - PWM: software sets lower compare nonzero and below overflow value.
// RULE22 - PWM with buffer: buffer loads lower compare on each overflow.
// RULE23 - Interval match clears counter, raises irq, toggles flop if enabled.
// RULE24 - Flop control 00 toggles, 01 sets, 10 clears, 11 holds.
// RULE25 - Pulse mode: lower counter restarts after upper compare match.
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module dtp_timer_pair (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire dtp_pkg::dtp_req_s req_i,
  output logic [dtp_pkg::DATA_W-1:0] rd_data_o,
  // Pins
  input wire logic external_count_input_i,
  output logic timer_output_pin_o,
  // Match events
  output logic lower_match_irq_o,
  output logic upper_match_irq_o
);
  import dtp_pkg::*;

  logic [7:0] pair_run_reg;
  logic [7:0] pair_mode_reg;
  logic [1:0] ffcr_sel;
  logic [7:0] lower_compare_value;
  logic [7:0] lower_compare_buf;
  logic [7:0] upper_compare_value;
  logic [7:0] lower_up_counter;
  logic [7:0] upper_up_counter;
  logic [7:0] presc;
  logic timer_output_flop;
  logic cmp_suspend;
  logic [2:0] ext_sync;

  dtp_mode_e op_mode;
  logic [1:0] lclk_sel;
  logic [1:0] uclk_sel;
  logic [1:0] pwm_cycle_select;
  logic lower_run;
  logic upper_run;
  logic lower_buffer_enable;
  logic wr_run;
  logic wr_lcmp;
  logic wr_ucmp;
  logic wr_mode;
  logic wr_ffcr;
  logic tap_fine;
  logic tap4;
  logic tap16;
  logic tap_coarse;
  logic ext_edge;
  logic l_tick;
  logic u_tick;
  logic [7:0] l_inc;
  logic [7:0] u_inc;
  logic [7:0] pwm_top;
  logic l_hit;
  logic u_hit;
  logic pair_hit;
  logic ppg_period;
  logic pwm_ovf;
  logic l_ovf;
  logic buf_load;
  logic lower_irq_ev;
  logic upper_irq_ev;
  logic hw_toggle;

  assign op_mode = dtp_mode_e'(pair_mode_reg[MODE_OP_LO +: 2]); // RULE7
  assign lclk_sel = pair_mode_reg[MODE_LCLK_LO +: 2];
  assign uclk_sel = pair_mode_reg[MODE_UCLK_LO +: 2];
  assign pwm_cycle_select = pair_mode_reg[MODE_PWM_LO +: 2];
  assign lower_run = pair_run_reg[RUN_LOWER];
  assign upper_run = pair_run_reg[RUN_UPPER];
  assign lower_buffer_enable = pair_run_reg[RUN_BUFEN];

  assign wr_run = req_i.wr && (req_i.addr == OFS_RUN);
  assign wr_lcmp = req_i.wr && (req_i.addr == OFS_LCMP);
  assign wr_ucmp = req_i.wr && (req_i.addr == OFS_UCMP);
  assign wr_mode = req_i.wr && (req_i.addr == OFS_MODE);
  assign wr_ffcr = req_i.wr && (req_i.addr == OFS_FFCR);

  // Prescaler: taps are one-cycle enables, never derived clocks
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presc <= CNT_RST;
    end else if (!pair_run_reg[RUN_PRESC]) begin
      presc <= CNT_RST;
    end else begin
      presc <= presc + 8'h01;
    end
  end

  assign tap_fine = pair_run_reg[RUN_PRESC];
  assign tap4 = tap_fine && ((presc & TAP4_MASK) == TAP4_MASK);
  assign tap16 = tap_fine && ((presc & TAP16_MASK) == TAP16_MASK);
  assign tap_coarse = tap_fine && ((presc & TAP256_MASK) == TAP256_MASK);

  // External input: two flops before the edge detector reads it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_sync <= 3'h0;
    end else begin
      ext_sync <= {ext_sync[1:0], external_count_input_i};
    end
  end

  assign ext_edge = ext_sync[1] && !ext_sync[2];

  // Clock selection
  always_comb begin
    unique case (lclk_sel) // RULE4
      2'b00: l_tick = lower_run && ext_edge;
      2'b01: l_tick = lower_run && tap_fine;
      2'b10: l_tick = lower_run && tap4;
      2'b11: l_tick = lower_run && tap16;
    endcase
  end

  assign l_inc = lower_up_counter + 8'h01;
  assign u_inc = upper_up_counter + 8'h01;
  assign l_ovf = l_tick && (lower_up_counter == PWM_TOP8);

  always_comb begin
    unique case (pwm_cycle_select) // RULE19
      2'b01: pwm_top = PWM_TOP6;
      2'b10: pwm_top = PWM_TOP7;
      2'b11: pwm_top = PWM_TOP8;
      2'b00: pwm_top = PWM_TOP8;
    endcase
  end

  // Lower comparator; suspended between low and high byte writes
  assign l_hit = l_tick && (l_inc == lower_compare_value) && !cmp_suspend;
  assign pair_hit = (op_mode == OP_TIMER16) && l_hit && (upper_up_counter == upper_compare_value); // RULE11
  assign ppg_period = (op_mode == OP_PPG) && l_tick && (l_inc == upper_compare_value); // RULE25
  // Cycle is 2^n-1 ticks, so wrap as the count steps onto the top value
  assign pwm_ovf = (op_mode == OP_PWM) && l_tick && (l_inc == pwm_top); // RULE20

  always_comb begin
    u_tick = 1'b0;
    if (upper_run) begin
      unique case (op_mode)
        OP_TIMER16: u_tick = l_ovf; // RULE8
        OP_PPG: u_tick = 1'b0; // RULE12
        OP_TIMER8, OP_PWM: begin
          unique case (uclk_sel) // RULE4
            2'b00: u_tick = l_hit; // RULE6
            2'b01: u_tick = tap_fine;
            2'b10: u_tick = tap16;
            2'b11: u_tick = tap_coarse;
          endcase
        end
      endcase
    end
  end

  assign u_hit = (op_mode != OP_TIMER16) && u_tick && (u_inc == upper_compare_value); // RULE18

  assign buf_load = lower_buffer_enable && (ppg_period || pwm_ovf); // RULE16 RULE22
  assign lower_irq_ev = ((op_mode == OP_TIMER8) && l_hit) || pwm_ovf || ppg_period; // RULE10
  assign upper_irq_ev = u_hit || pair_hit; // RULE23

  always_comb begin
    hw_toggle = 1'b0;
    if (ffcr_sel[FFCR_IE]) begin
      unique case (op_mode)
        OP_TIMER8: hw_toggle = ffcr_sel[FFCR_IS] ? u_hit : l_hit; // RULE5
        OP_TIMER16: hw_toggle = pair_hit; // RULE11
        OP_PPG: hw_toggle = l_hit || ppg_period; // RULE13
        OP_PWM: hw_toggle = l_hit || pwm_ovf; // RULE19
      endcase
    end
  end

  // Control registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pair_run_reg <= RUN_RST;
      pair_mode_reg <= MODE_RST;
      ffcr_sel <= 2'h0;
    end else begin
      if (wr_run) begin
        pair_run_reg <= req_i.wdata & RUN_RD_MASK;
      end
      if (wr_mode) begin
        pair_mode_reg <= req_i.wdata;
      end
      if (wr_ffcr) begin
        ffcr_sel <= req_i.wdata[1:0];
      end
    end
  end

  // Compare registers and buffer; buffered writes only touch the buffer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lower_compare_value <= CMP_RST;
      lower_compare_buf <= CMP_RST;
      upper_compare_value <= CMP_RST;
    end else begin
      if (wr_lcmp) begin
        lower_compare_buf <= req_i.wdata;
      end
      if (wr_lcmp && !lower_buffer_enable) begin
        lower_compare_value <= req_i.wdata;
      end else if (buf_load) begin
        lower_compare_value <= lower_compare_buf; // RULE16 RULE22
      end
      if (wr_ucmp) begin
        upper_compare_value <= req_i.wdata;
      end
    end
  end

  // Low byte first: suspend until the high byte arrives
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmp_suspend <= 1'b0;
    end else if (wr_ucmp) begin
      cmp_suspend <= 1'b0; // RULE9
    end else if (wr_lcmp && (op_mode == OP_TIMER16)) begin
      cmp_suspend <= 1'b1; // RULE9
    end
  end

  // Lower up-counter
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lower_up_counter <= CNT_RST;
    end else if (!lower_run) begin
      lower_up_counter <= CNT_RST; // RULE3
    end else if (l_tick) begin
      unique case (op_mode)
        OP_TIMER8: lower_up_counter <= l_hit ? CNT_RST : l_inc; // RULE1 RULE23
        OP_TIMER16: lower_up_counter <= pair_hit ? CNT_RST : l_inc; // RULE10 RULE11
        OP_PPG: lower_up_counter <= ppg_period ? CNT_RST : l_inc; // RULE25
        OP_PWM: lower_up_counter <= pwm_ovf ? CNT_RST : l_inc; // RULE20
      endcase
    end
  end

  // Upper up-counter
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      upper_up_counter <= CNT_RST;
    end else if (!upper_run) begin
      upper_up_counter <= CNT_RST; // RULE3
    end else if (pair_hit) begin
      upper_up_counter <= CNT_RST; // RULE11
    end else if (u_tick) begin
      upper_up_counter <= u_hit ? CNT_RST : u_inc; // RULE1 RULE23
    end
  end

  // Output flop: a software set, clear or toggle write wins over a same-cycle match toggle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_output_flop <= 1'b0;
    end else if (wr_ffcr && (req_i.wdata[FFCR_CTL_LO +: 2] != FF_HOLD)) begin
      unique case (dtp_ffctl_e'(req_i.wdata[FFCR_CTL_LO +: 2])) // RULE24 RULE17
        FF_TOGGLE: timer_output_flop <= !timer_output_flop;
        FF_SET: timer_output_flop <= 1'b1;
        FF_CLEAR: timer_output_flop <= 1'b0;
        FF_HOLD: timer_output_flop <= timer_output_flop;
      endcase
    end else if (hw_toggle) begin
      timer_output_flop <= !timer_output_flop; // RULE5 RULE13 RULE19
    end
  end

  assign timer_output_pin_o = timer_output_flop; // RULE12

  // Match pulses, one cycle after the event
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lower_match_irq_o <= 1'b0;
      upper_match_irq_o <= 1'b0;
    end else begin
      lower_match_irq_o <= lower_irq_ev; // RULE1
      upper_match_irq_o <= upper_irq_ev; // RULE1
    end
  end

  // Read port: data in the cycle after the strobe only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 8'h00;
    end else if (req_i.rd) begin
      unique case (req_i.addr)
        OFS_RUN: rd_data_o <= pair_run_reg;
        OFS_MODE: rd_data_o <= pair_mode_reg;
        OFS_FFCR: rd_data_o <= {4'h0, FFCR_CTL_RD, ffcr_sel};
        OFS_LCNT: rd_data_o <= lower_up_counter;
        OFS_UCNT: rd_data_o <= upper_up_counter;
        OFS_STAT: rd_data_o <= {6'h00, cmp_suspend, timer_output_flop};
        default: rd_data_o <= 8'h00;
      endcase
    end else begin
      rd_data_o <= 8'h00;
    end
  end

  // Checks
  a_run_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE3
    !lower_run |=> lower_up_counter == CNT_RST) else $error("lower counter not cleared while stopped");
  a_t8_match_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE23
    (op_mode == OP_TIMER8) && l_hit && lower_run |=> lower_up_counter == CNT_RST)
    else $error("timer8 match did not clear counter");
  a_t8_irq_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE1
    (op_mode == OP_TIMER8) && l_hit |=> lower_match_irq_o ##1 !lower_match_irq_o || $past(l_hit))
    else $error("lower irq pulse missing");
  a_t16_no_lclear: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE10
    (op_mode == OP_TIMER16) && l_hit && !pair_hit && lower_run |=> lower_up_counter == $past(l_inc))
    else $error("16-bit lower match cleared counter");
  a_t16_no_lirq: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE10
    (op_mode == OP_TIMER16) |=> !lower_match_irq_o || $past(op_mode != OP_TIMER16))
    else $error("lower irq raised in 16-bit mode");
  a_t16_pair: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE11
    pair_hit && upper_run |=> upper_up_counter == CNT_RST && lower_up_counter == CNT_RST && upper_match_irq_o)
    else $error("16-bit match did not clear both counters");
  a_t16_upper_clk: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE8
    (op_mode == OP_TIMER16) && upper_run && !l_ovf && !pair_hit |=> $stable(upper_up_counter))
    else $error("upper counted without lower overflow");
  a_susp_blocks: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE9
    cmp_suspend && (op_mode == OP_TIMER16) |=> !upper_match_irq_o)
    else $error("16-bit match while compare suspended");
  a_susp_set: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE9
    (op_mode == OP_TIMER16) && wr_lcmp |=> cmp_suspend) else $error("low byte write did not suspend compare");
  a_ppg_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE25
    ppg_period && lower_run |=> lower_up_counter == CNT_RST) else $error("pulse period did not restart counter");
  a_flop_toggle: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE5
    hw_toggle && !wr_ffcr |=> timer_output_pin_o != $past(timer_output_pin_o))
    else $error("flop did not toggle on match");
  a_flop_sw: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE24
    wr_ffcr && (req_i.wdata[FFCR_CTL_LO +: 2] == FF_SET) |=> timer_output_pin_o)
    else $error("software set of flop failed");
  a_pwm_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE20
    pwm_ovf && lower_run |=> lower_up_counter == CNT_RST) else $error("PWM overflow did not clear");
  a_buf_load: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE22
    buf_load && !wr_lcmp |=> lower_compare_value == $past(lower_compare_buf))
    else $error("buffer not transferred");
  c_t16_pair: cover property (@(posedge clk_i) disable iff (!rst_n_i) pair_hit);
  c_ext_count: cover property (@(posedge clk_i) disable iff (!rst_n_i) ext_edge && l_tick);
  c_ppg_period: cover property (@(posedge clk_i) disable iff (!rst_n_i) ppg_period && buf_load);
  c_pwm_cycle: cover property (@(posedge clk_i) disable iff (!rst_n_i) (op_mode == OP_PWM) && l_hit ##[1:300] pwm_ovf);
endmodule

// file: sim/dtp_timer_pair_bench.sv
// Purpose: Self-checking bench for the dual 8-bit timer pair
// Assumes: Register port with one-cycle strobes, read data one cycle later
// Notes: Periods are measured between match pulses, so start-up latency cancels out
`timescale 1ns/1ps
module dtp_timer_pair_bench;
  import dtp_pkg::*;
  logic clk_i;
  logic rst_n_i;
  logic ext;
  dtp_req_s req;
  logic [7:0] rd_data;
  logic pin;
  logic lirq;
  logic uirq;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int n_lirq = 0;
  int seed;
  int per;
  int tog;
  int off;
  int off1;
  int base;
  logic [7:0] d;
  logic [7:0] n;
  logic [7:0] m;
  int divl [3] = '{1, 4, 16};
  int divu [3] = '{1, 16, 256};
  dtp_ffctl_e ctlt [4] = '{FF_SET, FF_CLEAR, FF_TOGGLE, FF_HOLD};
  logic fexp [4] = '{1'b1, 1'b0, 1'b1, 1'b1};

  dtp_timer_pair dtp_timer_pair_i (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .req_i(req),
    .rd_data_o(rd_data),
    .external_count_input_i(ext),
    .timer_output_pin_o(pin),
    .lower_match_irq_o(lirq),
    .upper_match_irq_o(uirq)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Run is far shorter than this; reaching it means a hang
  always @(posedge clk_i) begin
    cyc++;
    if (lirq === 1'b1) n_lirq++;
    if (cyc == 100000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  function automatic logic [7:0] rnd(input int lo, input int span);
    return 8'(lo + $unsigned($random(seed)) % span);
  endfunction

  function automatic logic irq(input bit u);
    return u ? uirq : lirq;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_i);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    req.wr <= 1'b0;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chki(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      n_errors++;
      $display("[FAIL] %0t measured %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [7:0] e, input logic [7:0] mask);
    logic [7:0] v;
    @(posedge clk_i);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    req.rd <= 1'b0;
    #1;
    v = rd_data;
    chk8(v & mask, e);
  endtask

  task automatic cfg(input logic [7:0] mode, input logic [7:0] lc, input logic [7:0] uc,
                     input logic [7:0] ff, input logic [7:0] run);
    wr(OFS_RUN, RUN_RST);
    wr(OFS_MODE, mode);
    wr(OFS_LCMP, lc);
    wr(OFS_UCMP, uc);
    wr(OFS_FFCR, ff);
    wr(OFS_RUN, run);
  endtask

  // Interval between two match pulses, output flop changes and first change offset
  task automatic measure(input bit u);
    logic f;
    int i;
    i = 0;
    while (irq(u) !== 1'b1 && i < 3000) begin
      @(posedge clk_i);
      #1;
      i++;
    end
    f = pin;
    per = 0;
    tog = 0;
    off = -1;
    do begin
      @(posedge clk_i);
      #1;
      per++;
      if (pin !== f && off < 0) off = per;
      if (pin !== f) tog++;
      f = pin;
    end while (irq(u) !== 1'b1 && per < 3000);
  endtask

  initial begin
    seed = 32'h8d72c990;
    ext = 1'b0;
    rst_n_i = 1'b0;
    req = '0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rdchk(OFS_RUN, RUN_RST, 8'hFF);
    rdchk(OFS_MODE, MODE_RST, 8'hFF);
    rdchk(OFS_LCMP, CMP_RST, 8'hFF);
    rdchk(OFS_LCNT, CNT_RST, 8'hFF);
    rdchk(OFS_FFCR, {4'h0, FFCR_CTL_RD, 2'b00}, 8'hFF);
    rdchk(OFS_STAT, 8'h00, 8'hFF);
    rdchk(4'hF, 8'h00, 8'hFF);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_FFCR, {4'h0, ctlt[k], 2'b00});
      rdchk(OFS_STAT, {7'h00, fexp[k]}, 8'h01);
    end
    for (int k = 0; k < 3; k++) begin
      n = rnd(2, 12);
      cfg({6'h00, 2'(k + 1)}, n, 8'h00, 8'h0E, 8'h05);
      measure(0);
      chki(per, n * divl[k]);
      chki(tog, 1);
      m = rnd(2, 4);
      cfg({4'h0, 2'(k + 1), 2'b01}, 8'h00, m, 8'h0F, 8'h06);
      measure(1);
      chki(per, m * divu[k]);
      chki(tog, 1);
    end
    n = rnd(2, 12);
    m = rnd(2, 12);
    cfg(8'h01, n, m, 8'h0C, 8'h07);
    measure(1);
    chki(per, n * m);
    wr(OFS_RUN, 8'h04);
    rdchk(OFS_LCNT, 8'h00, 8'hFF);
    rdchk(OFS_UCNT, 8'h00, 8'hFF);
    // Upper clock field set to a tap on purpose: cascade must ignore it
    n = rnd(1, 255);
    wr(OFS_MODE, 8'h4D);
    wr(OFS_LCMP, n);
    rdchk(OFS_STAT, 8'h02, 8'h02);
    wr(OFS_UCMP, 8'h01);
    rdchk(OFS_STAT, 8'h00, 8'h02);
    wr(OFS_FFCR, 8'h0E);
    wr(OFS_RUN, 8'h07);
    measure(1);
    base = n_lirq;
    measure(1);
    chki(per, 256 + n);
    chki(tog, 1);
    chki(n_lirq - base, 0);
    for (int k = 0; k < 3; k++) begin
      n = rnd(1, 62);
      m = rnd(2, 12);
      cfg({2'b11, 2'(k + 1), 4'b0101}, n, m, 8'h0A, 8'h07);
      measure(0);
      chki(per, (1 << (6 + k)) - 1);
      chki(tog, 2);
      off1 = off;
      measure(1);
      chki(per, m);
    end
    // New duty lands only at a wrap, so the second full cycle shows it
    d = n + 8'h03;
    wr(OFS_RUN, 8'h87);
    wr(OFS_LCMP, d);
    measure(0);
    measure(0);
    chki(off - off1, int'(d) - int'(n));
    n = rnd(2, 20);
    m = n + rnd(5, 20);
    d = n + 8'h03;
    cfg(8'h81, n, m, 8'h0A, 8'h07);
    measure(0);
    chki(per, m);
    chki(tog, 2);
    chk8({7'h00, pin}, 8'h00);
    off1 = off;
    wr(OFS_RUN, 8'h87);
    wr(OFS_LCMP, d);
    measure(0);
    measure(0);
    chki(off - off1, int'(d) - int'(n));
    cfg(8'h00, 8'h03, 8'h00, 8'h0C, 8'h01);
    base = n_lirq;
    repeat (6) begin
      @(posedge clk_i);
      ext <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    repeat (10) @(posedge clk_i);
    chki(n_lirq - base, 2);
    complete_run();
  end
endmodule
